// ### inc/fsop_pkg.sv
// constants, register layout and types of the framed serial output port
// ============================================================
// Notes on behaviour
// - frame sync sampled on shift clock fall; slot starts at next rise
// - frame sync and shift clock pins drive out only as bus master
// - master pulses frame sync high one shift clock cycle before a slot
// - frame end flag rises with the last data bit, for its whole cycle
// - a frame sync at frame end restarts with no idle gap
// - word length code: 00 16 bits, 01 24 bits, 10 32 bits, 11 illegal
// - words go MSB first, left justified, padding zeros at the end
// - 24 and 32 bit words carry 23 significant sample bits
// - frame holds I and Q of A, plus B in diversity mode
// - append option adds a read data word, zero when nothing was read
// - a pending register read adds the read word even without append
// - master shift clock is core clock over 2, or over 2N for N nonzero
// - as slave the divider is ignored and external clock and sync used
// - serial input sampled on falling edges, outputs change on rising
// - serial output released outside the port's own active slot
// - read word carries two, three or four bytes by word length
package fsop_pkg;
    // ============================================================
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SAMP_AI = 8'h04;
    localparam logic [7:0] ADDR_SAMP_AQ = 8'h08;
    localparam logic [7:0] ADDR_SAMP_BI = 8'h0C;
    localparam logic [7:0] ADDR_SAMP_BQ = 8'h10;
    localparam logic [7:0] ADDR_RDATA = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_START = 8'h1C;
    localparam logic [7:0] ADDR_SIN = 8'h20;
    // ============================================================
    // word length codes and bit counts
    localparam logic [1:0] WL_16 = 2'h0;
    localparam logic [1:0] WL_24 = 2'h1;
    localparam logic [1:0] WL_32 = 2'h2;
    localparam logic [1:0] WL_BAD = 2'h3;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_24 = 6'h18;
    localparam logic [5:0] BITS_32 = 6'h20;
    // ============================================================
    // field layout of CTRL bits [8:0], low field last
    typedef struct packed {
        logic [3:0] divider;
        logic diversity;
        logic busMaster;
        logic appendData;
        logic [1:0] wordLen;
    } fsop_ctrl_t;
    localparam logic [8:0] CTRL_RESET = 9'h000;
    localparam int SAMPLE_W = 24;
    typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_ACTIVE} fsop_state_t;
endpackage

// ### hw/fsop_port.sv
// framed serial output port with wishbone register access
`timescale 1ns/100ps
module fsop_port
(
    // system
    input wire logic clock,
    input wire logic reset,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    // shift clock pin
    input wire logic shiftClkIn,
    output logic shiftClkOut,
    output logic shiftClkOe,
    // frame sync pin
    input wire logic frameSyncIn,
    output logic frameSyncOut,
    output logic frameSyncOe,
    // serial data and frame end
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOe,
    output logic frameEndFlag
);
    // ============================================================
    // state
    fsop_pkg::fsop_ctrl_t ctrl_r;
    fsop_pkg::fsop_state_t state_r;
    logic [fsop_pkg::SAMPLE_W-1:0] sample_r [4];
    logic [31:0] readData_r, appendWord_r, shift_r, sinWord_r, nextWord;
    logic readPending_r, startPending_r, fsSeen_r, sclkPrev_r, appendFrame_r;
    logic [3:0] divCnt_r;
    logic [5:0] bitCnt_r;
    logic [2:0] wordIdx_r, lastWord_r, nextIdx;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
        input logic [31:0] wr, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                res[i*8 +: 8] = wr[i*8 +: 8];
        end
        return res;
    endfunction

    function automatic logic [5:0] wordBits(input logic [1:0] wl);
        if (wl == fsop_pkg::WL_24)
            return fsop_pkg::BITS_24;
        else if (wl == fsop_pkg::WL_32)
            return fsop_pkg::BITS_32;
        else
            return fsop_pkg::BITS_16;
    endfunction

    // left justified; wider words keep 23 sample bits then pad zeros
    function automatic logic [31:0] fitSample(input logic [23:0] s,
        input logic [1:0] wl);
        if (wl == fsop_pkg::WL_16)
            return {s[23:8], 16'h0000};
        else
            return {s[23:1], 9'h000};
    endfunction

    // ============================================================
    // shift clock: generated as master, sampled as slave
    wire isMaster = ctrl_r.busMaster;
    wire [3:0] halfLen = (ctrl_r.divider == 4'h0) ? 4'h1 : ctrl_r.divider;
    wire tick = divCnt_r >= halfLen - 4'h1;
    wire riseEv = isMaster ? (tick & ~shiftClkOut)
                           : (shiftClkIn & ~sclkPrev_r);
    wire fallEv = isMaster ? (tick & shiftClkOut)
                           : (~shiftClkIn & sclkPrev_r);
    wire fsLevel = isMaster ? frameSyncOut : frameSyncIn;

    always_ff @(posedge clock)
    begin
        if (reset || !isMaster)
        begin
            divCnt_r <= 4'h0;
            shiftClkOut <= 1'b0;
        end
        else if (tick)
        begin
            // half period of halfLen core cycles keeps both phases equal
            divCnt_r <= 4'h0;
            shiftClkOut <= ~shiftClkOut;
        end
        else
            divCnt_r <= divCnt_r + 4'h1;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sclkPrev_r <= 1'b0;
            shiftClkOe <= 1'b0;
            frameSyncOe <= 1'b0;
        end
        else
        begin
            sclkPrev_r <= shiftClkIn;
            shiftClkOe <= isMaster;
            frameSyncOe <= isMaster;
        end
    end

    // only a sync seen on the fall just before a rise counts
    always_ff @(posedge clock)
    begin
        if (reset)
            fsSeen_r <= 1'b0;
        else if (fallEv)
            fsSeen_r <= fsLevel;
        else if (riseEv)
            fsSeen_r <= 1'b0;
    end

    // ============================================================
    // frame engine
    wire isActive = state_r == fsop_pkg::ST_ACTIVE;
    wire lastRise = riseEv & isActive & bitCnt_r == 6'h0
                    & wordIdx_r == lastWord_r;
    wire frameStart = riseEv & fsSeen_r & (!isActive | lastRise);
    wire masterKick = isMaster & riseEv & startPending_r
                      & state_r == fsop_pkg::ST_IDLE;
    wire appendNow = ctrl_r.appendData | readPending_r;
    wire [5:0] curBits = wordBits(ctrl_r.wordLen);

    always_comb
    begin
        nextIdx = frameStart ? 3'h0 : wordIdx_r + 3'h1;
        if (!frameStart && appendFrame_r && nextIdx == lastWord_r)
            nextWord = appendWord_r;
        else
            nextWord = fitSample(sample_r[nextIdx[1:0]], ctrl_r.wordLen);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_r <= fsop_pkg::ST_IDLE;
            frameSyncOut <= 1'b0;
            serialOut <= 1'b0;
            serialOe <= 1'b0;
            frameEndFlag <= 1'b0;
            shift_r <= 32'h00000000;
            bitCnt_r <= 6'h0;
            wordIdx_r <= 3'h0;
            lastWord_r <= 3'h0;
            appendFrame_r <= 1'b0;
            appendWord_r <= 32'h00000000;
        end
        else if (frameStart)
        begin
            state_r <= fsop_pkg::ST_ACTIVE;
            frameSyncOut <= 1'b0;
            serialOut <= nextWord[31];
            serialOe <= 1'b1;
            frameEndFlag <= 1'b0;
            shift_r <= nextWord;
            bitCnt_r <= curBits - 6'h1;
            wordIdx_r <= 3'h0;
            lastWord_r <= {1'b0, ctrl_r.diversity, 1'b1}
                          + {2'b00, appendNow};
            appendFrame_r <= appendNow;
            appendWord_r <= readPending_r ? readData_r : 32'h00000000;
        end
        else if (masterKick)
        begin
            state_r <= fsop_pkg::ST_SYNC;
            frameSyncOut <= 1'b1;
        end
        else if (riseEv && isActive)
        begin
            if (bitCnt_r != 6'h0)
            begin
                serialOut <= shift_r[30];
                shift_r <= {shift_r[30:0], 1'b0};
                bitCnt_r <= bitCnt_r - 6'h1;
                frameEndFlag <= bitCnt_r == 6'h1
                                && wordIdx_r == lastWord_r;
            end
            else if (wordIdx_r != lastWord_r)
            begin
                serialOut <= nextWord[31];
                shift_r <= nextWord;
                bitCnt_r <= curBits - 6'h1;
                wordIdx_r <= nextIdx;
                frameEndFlag <= 1'b0;
            end
            else
            begin
                state_r <= fsop_pkg::ST_IDLE;
                serialOe <= 1'b0;
                frameEndFlag <= 1'b0;
            end
        end
        else if (riseEv && state_r == fsop_pkg::ST_SYNC)
        begin
            // sync was lost (role changed): give the slot up
            state_r <= fsop_pkg::ST_IDLE;
            frameSyncOut <= 1'b0;
        end
    end

    // command decoding lies elsewhere; the input word is only captured
    always_ff @(posedge clock)
    begin
        if (reset)
            sinWord_r <= 32'h00000000;
        else if (fallEv && isActive)
            sinWord_r <= {sinWord_r[30:0], serialIn};
    end

    // ============================================================
    // wishbone slave: ack one cycle after the request, writes at ack
    wire busWrite = cyc_i & stb_i & we_i & ack_o;
    wire [31:0] ctrlMerged = mergeBytes({23'h0, ctrl_r}, dat_i, sel_i);

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ctrl_r <= fsop_pkg::CTRL_RESET;
            readData_r <= 32'h00000000;
            readPending_r <= 1'b0;
            startPending_r <= 1'b0;
            for (int i = 0; i < 4; i++)
                sample_r[i] <= 24'h000000;
        end
        else
        begin
            // a new request beats the clear of the same cycle
            readPending_r <= (busWrite && adr_i == fsop_pkg::ADDR_RDATA)
                             || (readPending_r && !frameStart);
            startPending_r <= (busWrite && adr_i == fsop_pkg::ADDR_START)
                              || (startPending_r && !masterKick);
            if (busWrite && adr_i == fsop_pkg::ADDR_CTRL)
            begin
                ctrl_r.divider <= ctrlMerged[8:5];
                ctrl_r.diversity <= ctrlMerged[4];
                ctrl_r.busMaster <= ctrlMerged[3];
                ctrl_r.appendData <= ctrlMerged[2];
                if (ctrlMerged[1:0] != fsop_pkg::WL_BAD)
                    ctrl_r.wordLen <= ctrlMerged[1:0];
            end
            if (busWrite && adr_i == fsop_pkg::ADDR_RDATA)
                readData_r <= mergeBytes(readData_r, dat_i, sel_i);
            for (int i = 0; i < 4; i++)
            begin
                if (busWrite && adr_i == fsop_pkg::ADDR_SAMP_AI + 8'(4 * i))
                    sample_r[i] <= 24'(mergeBytes({8'h00, sample_r[i]},
                                                  dat_i, sel_i));
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            unique case (adr_i)
                fsop_pkg::ADDR_CTRL: dat_o <= {23'h0, ctrl_r};
                fsop_pkg::ADDR_SAMP_AI: dat_o <= {8'h00, sample_r[0]};
                fsop_pkg::ADDR_SAMP_AQ: dat_o <= {8'h00, sample_r[1]};
                fsop_pkg::ADDR_SAMP_BI: dat_o <= {8'h00, sample_r[2]};
                fsop_pkg::ADDR_SAMP_BQ: dat_o <= {8'h00, sample_r[3]};
                fsop_pkg::ADDR_RDATA: dat_o <= readData_r;
                fsop_pkg::ADDR_STATUS: dat_o <= {29'h0, startPending_r,
                                                 readPending_r, isActive};
                fsop_pkg::ADDR_SIN: dat_o <= sinWord_r;
                default: dat_o <= 32'h00000000;
            endcase
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sync_start_a: assert property (
        riseEv && fsSeen_r && !isActive |=> isActive && serialOe)
        else $error("slot did not start after sampled frame sync");
    pin_dir_a: assert property (
        $past(ctrl_r.busMaster) |-> shiftClkOe && frameSyncOe)
        else $error("master pins not driven");
    sync_pulse_a: assert property (
        frameSyncOut && !riseEv |=> frameSyncOut)
        else $error("frame sync pulse dropped before shift clock rise");
    sync_drop_a: assert property (
        frameSyncOut && riseEv |=> !frameSyncOut)
        else $error("frame sync held past one shift clock cycle");
    end_flag_a: assert property (
        $rose(frameEndFlag) |-> bitCnt_r == 6'h0 && wordIdx_r == lastWord_r)
        else $error("frame end not with last bit");
    wl_legal_a: assert property (
        ctrl_r.wordLen != fsop_pkg::WL_BAD)
        else $error("illegal word length stored");
    msb_first_a: assert property (
        riseEv && isActive && bitCnt_r != 6'h0
        |=> serialOut == $past(shift_r[30]))
        else $error("bit order wrong");
    word_count_a: assert property (
        frameStart |=> lastWord_r == ($past(ctrl_r.diversity) ? 3'h3 : 3'h1)
        + 3'($past(appendNow)))
        else $error("words per frame wrong");
    read_append_a: assert property (
        frameStart && readPending_r |=> appendFrame_r
        && appendWord_r == $past(readData_r))
        else $error("pending read not appended");
    div_even_a: assert property (
        isMaster && $past(isMaster) && ctrl_r.divider == 4'h0
        && $past(ctrl_r.divider) == 4'h0 |-> shiftClkOut != $past(shiftClkOut))
        else $error("undivided master clock not toggling each cycle");
    slave_clk_a: assert property (
        !isMaster |=> divCnt_r == 4'h0 && !shiftClkOut)
        else $error("divider running as slave");
    oe_slot_a: assert property (
        !isActive |-> !serialOe)
        else $error("serial output driven outside slot");

    diversity_c: cover property (frameStart && ctrl_r.diversity);
    chained_c: cover property (lastRise && frameStart);
    append_c: cover property (frameStart && ctrl_r.appendData);
    kick_c: cover property (masterKick ##[1:40] frameStart);
endmodule

// ### bench/fsop_dsp_model.sv
// behavioural far-side serial port: slave clock and sync, bit capture
`timescale 1ns/100ps
module fsop_dsp_model
(
    // system
    input wire logic clock,
    // wire levels
    input wire logic clkWire,
    input wire logic syncWire,
    input wire logic dataWire,
    input wire logic dataOe,
    input wire logic frameEnd,
    // sclk and syncR driven in place of the device when it is a slave; sin drives its serial input always
    output logic sclk,
    output logic syncR,
    output logic sin
);
    logic [2:0] bits[$];
    logic clkPrev = 1'b0;
    logic syncPrev = 1'b0;
    int cyc = 0;
    int lastRise = 0;
    int period = 0;
    initial
    begin
        sclk = 1'b0;
        syncR = 1'b0;
        sin = 1'b0;
    end
    // input toggles every cycle so a stale level never passes for data
    always @(posedge clock)
    begin
        sin <= ~sin;
        cyc <= cyc + 1;
        clkPrev <= clkWire;
        if (clkWire && !clkPrev)
        begin
            period <= cyc - lastRise;
            lastRise <= cyc;
        end
        if (!clkWire && clkPrev)
        begin
            syncPrev <= syncWire;
            if (dataOe)
                bits.push_back({syncPrev, frameEnd, dataWire});
        end
    end
    // one sync pulse per frame, clock idles low outside frames
    task automatic runFrame(input int periods, input int half);
        sclk <= 1'b1;
        syncR <= 1'b1;
        repeat (half) @(posedge clock);
        sclk <= 1'b0;
        repeat (half) @(posedge clock);
        syncR <= 1'b0;
        // several core cycles each phase keeps the rate legal
        repeat (periods)
        begin
            sclk <= 1'b1;
            repeat (half) @(posedge clock);
            sclk <= 1'b0;
            repeat (half) @(posedge clock);
        end
    endtask
endmodule

// ### bench/testbench.sv
// self-checking bench: register access, master, slave and chained frames
`timescale 1ns/100ps
module testbench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'hF;
    logic chainOn = 1'b0;
    logic ack, sClkO, sClkOe, fsO, fsOe, sOut, sOe, fe, dClk, dSync, dSin;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic [23:0] samp[4];
    logic [2:0] exp[$];
    int fail_count = 0;
    int num_checks = 0;
    wire clkWire = sClkOe ? sClkO : dClk;
    wire syncWire = fsOe ? fsO : (dSync | (chainOn & fe));
    // pull-down holds the released data line low
    wire dataWire = sOe ? sOut : 1'b0;
    fsop_port uut (.clock(clock), .reset(reset), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel), .ack_o(ack),
        .dat_o(rdat), .shiftClkIn(clkWire), .shiftClkOut(sClkO),
        .shiftClkOe(sClkOe), .frameSyncIn(syncWire), .frameSyncOut(fsO),
        .frameSyncOe(fsOe), .serialIn(dSin), .serialOut(sOut),
        .serialOe(sOe), .frameEndFlag(fe));
    fsop_dsp_model dsp (.clock(clock), .clkWire(clkWire),
        .syncWire(syncWire), .dataWire(dataWire), .dataOe(sOe),
        .frameEnd(fe), .sclk(dClk), .syncR(dSync), .sin(dSin));
    initial
    begin
        forever #50 clock = ~clock;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? ack : (s == 1 ? sOe : fe);
    endfunction
    task automatic waitFor(input int s, input logic v);
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end while (pick(s) !== v && n < 4000);
        if (n >= 4000)
            fail_count++;
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        waitFor(0, 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    function automatic logic [31:0] sampWord(input logic [23:0] s,
        input logic [1:0] wl);
        return wl == fsop_pkg::WL_16 ? {s[23:8], 16'h0000} :
            {s[23:1], 9'h000};
    endfunction
    task automatic addWord(input logic [31:0] w, input int n);
        for (int b = 0; b < n; b++)
            exp.push_back({2'h0, w[31 - b]});
    endtask
    task automatic addFrame(input fsop_pkg::fsop_ctrl_t c, input logic pend,
        input int n);
        int s;
        s = exp.size();
        for (int k = 0; k < (c.diversity ? 4 : 2); k++)
            addWord(sampWord(samp[k], c.wordLen), n);
        if (c.appendData || pend)
            addWord(pend ? rd : 32'h0, n);
        exp[s][2] = 1'b1;
        exp[exp.size() - 1][1] = 1'b1;
    endtask
    task automatic frame(input fsop_pkg::fsop_ctrl_t c, input logic pend,
        input logic chain);
        logic [31:0] q;
        int n;
        n = c.wordLen == fsop_pkg::WL_16 ? 16 :
            (c.wordLen == fsop_pkg::WL_24 ? 24 : 32);
        wb(1'b1, fsop_pkg::ADDR_CTRL, {23'h0, c}, q);
        for (int k = 0; k < 4; k++)
            wb(1'b1, fsop_pkg::ADDR_SAMP_AI + 8'(4 * k), {8'h00, samp[k]}, q);
        if (pend)
            wb(1'b1, fsop_pkg::ADDR_RDATA, rd, q);
        exp.delete();
        addFrame(c, pend, n);
        // the pending read is served by the first slot of a chained pair
        if (chain)
            addFrame(c, 1'b0, n);
        dsp.bits.delete();
        if (c.busMaster)
        begin
            wb(1'b1, fsop_pkg::ADDR_START, 32'h1, q);
            waitFor(1, 1'b1);
            waitFor(1, 1'b0);
            check(dsp.period, 2 * (c.divider == 0 ? 1 : c.divider));
        end
        else
        begin
            chainOn <= chain;
            fork
                dsp.runFrame(exp.size() + 2, 3);
                if (chain)
                begin
                    waitFor(2, 1'b1);
                    waitFor(2, 1'b0);
                    chainOn <= 1'b0;
                end
            join
        end
        check({sClkOe, fsOe}, {2{c.busMaster}});
        check(dsp.bits.size(), exp.size());
        foreach (exp[b])
            if (b < dsp.bits.size())
                check(dsp.bits[b], exp[b]);
        check(sOe, 1'b0);
        wb(1'b0, fsop_pkg::ADDR_STATUS, 32'h0, q);
        check(q, 32'h0);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clock);
        fail_count++;
        summarize();
    end
    initial
    begin
        fsop_pkg::fsop_ctrl_t c;
        logic [31:0] q;
        logic pend;
        void'($urandom(32'hF179));
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        check({ack, sClkOe, fsOe, sOe, fe}, 32'h0);
        wb(1'b0, fsop_pkg::ADDR_CTRL, 32'h0, q);
        check(q, {23'h0, fsop_pkg::CTRL_RESET});
        wb(1'b0, 8'hFC, 32'h0, q);
        check(q, 32'h0);
        wb(1'b1, fsop_pkg::ADDR_CTRL, 32'h1, q);
        wb(1'b1, fsop_pkg::ADDR_CTRL, 32'h7, q);
        wb(1'b0, fsop_pkg::ADDR_CTRL, 32'h0, q);
        check(q, 32'h5);
        // masters first, then slaves, the last two chained
        for (int i = 0; i < 15; i++)
        begin
            c = 9'($urandom());
            c.wordLen = 2'(i % 3);
            c.busMaster = i < 11;
            c.divider[3:2] = 2'h0;
            for (int k = 0; k < 4; k++)
                samp[k] = 24'($urandom());
            rd = $urandom();
            pend = 1'($urandom());
            if (i == 0)
            begin
                c.appendData = 1'b1;
                pend = 1'b0;
            end
            frame(c, pend, i >= 13);
        end
        summarize();
    end
endmodule
